/* logic/icd_pkg.sv */
// constants and types for the i2c master command decoder
//
// Overview of operation
// RQ1: transmit state, dir1 ack0 stop1 start1 run1: restart, send, stop, idle
// RQ2: transmit state, dir1 ack1 stop0 start1 run1: restart, receive, to receive
// RQ3: receive state, ack0 stop0 start0 run1: receive with nack, stay receive
// RQ4: receive state, stop1 start0 run0: stop only, go idle
// RQ5: receive state, ack0 stop1 start0 run1: receive, stop, go idle
// RQ6: receive state, ack1 stop0 start0 run1: receive with ack, stay receive
// RQ7: receive, dir1 ack0 stop0 start1 run1: restart, receive nack, stay receive
// RQ8: receive, dir1 ack0 stop1 start1 run1: restart, receive, stop, go idle
// RQ9: receive, dir1 ack1 stop0 start1 run1: restart, receive ack, stay receive
// RQ10: receive, dir0 stop0 start1 run1: restart, send, go to transmit
// RQ11: receive, dir0 stop1 start1 run1: restart, send, stop, go idle
// RQ12: don't-care bits never change the selected action
// RQ13: software should stop in receive only after a nack
// RQ14: transmit, dir0 stop0 start1 run1: restart, send, stay transmit
// RQ15: data register supplies sent byte and captures received byte
// RQ16: illegal or unlisted commands start nothing and keep the state; transmit start1 run1 with dir1 ack0 stop0 or dir0 stop1 still acts
package icd_pkg;
   // register byte offsets
   localparam logic [7:0] ICD_SLAVE_ADDRESS_OFS = 8'h00;
   localparam logic [7:0] ICD_CONTROL_STATUS_OFS = 8'h04;
   localparam logic [7:0] ICD_DATA_OFS = 8'h08;
   localparam logic [7:0] ICD_STATE_OFS = 8'h0c;
   // control field positions; dir is a bit of the slave address register
   localparam int ICD_RUN_BIT = 0;
   localparam int ICD_START_BIT = 1;
   localparam int ICD_STOP_BIT = 2;
   localparam int ICD_ACK_BIT = 3;
   localparam int ICD_DIR_BIT = 0;
   // status field positions
   localparam int ICD_BUSY_BIT = 0;
   localparam int ICD_ERROR_BIT = 1;
   // reset values
   localparam logic [7:0] ICD_ADDR_RST = 8'h00;
   localparam logic [7:0] ICD_DATA_RST = 8'h00;
   // axi responses
   localparam logic [1:0] ICD_RESP_OKAY = 2'h0;
   localparam logic [1:0] ICD_RESP_SLVERR = 2'h2;
   // bus timing: scl quarter period in system clocks
   localparam int ICD_CLK_MHZ = 125;
   localparam int ICD_QUARTER_NS = 2500;
   localparam int ICD_QUARTER_CYC = (ICD_QUARTER_NS * ICD_CLK_MHZ) / 1000;
   localparam int ICD_FIFO_DEPTH = 16;

   typedef enum logic [1:0] {ICD_IDLE, ICD_MTX, ICD_MRX} icd_mstate_t;
   typedef enum logic [3:0] {
      ICD_B_IDLE, ICD_B_START, ICD_B_BIT, ICD_B_ACK, ICD_B_STOP
   } icd_bstate_t;
endpackage

/* logic/icd_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module icd_fifo
   import icd_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = ICD_FIFO_DEPTH
)(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("fifo depth must be a power of two, at least 2");
   end
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic push, pop;

   always_comb
   begin
      in_ready_out = (wr_r - rd_r) != (AW+1)'(DEPTH);
      out_valid_out = wr_r != rd_r;
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      wr_nxt = wr_r + (AW+1)'(push);
      rd_nxt = rd_r + (AW+1)'(pop);
      out_data_out = mem_r[rd_r[AW-1:0]];
   end

   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         wr_r <= '0;
         rd_r <= '0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end

   // storage has no reset; only pointers matter
   always_ff @(posedge clk_sys_in)
   begin
      if (push)
         mem_r[wr_r[AW-1:0]] <= in_data_in;
   end
endmodule

/* logic/icd_top.sv */
// i2c master command decoder with axi4-lite registers and bus engine
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module icd_top
   import icd_pkg::*;
#(
   parameter int QUARTER_CYC = ICD_QUARTER_CYC
)(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // axi4-lite write address and data
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // i2c pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // received bytes stream
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output logic [7:0] rx_data_out
);
   initial
   begin
      if (QUARTER_CYC < 1 || QUARTER_CYC > 65536)
         $error("quarter period must be at least one cycle");
   end

   // action bundle from decoding a command
   typedef struct packed {
      logic go;
      logic restart;
      logic xmit;
      logic recv;
      logic ackit;
      logic stop;
      icd_mstate_t nxt;
   } icd_act_t;

   // decode one command against the current master state
   function automatic icd_act_t decode(icd_mstate_t st, logic dir,
      logic [3:0] c);
      icd_act_t a;
      logic run, sta, sto, ack;
      run = c[ICD_RUN_BIT];
      sta = c[ICD_START_BIT];
      sto = c[ICD_STOP_BIT];
      ack = c[ICD_ACK_BIT];
      a = '{go: 1'b0, restart: 1'b0, xmit: 1'b0, recv: 1'b0,
         ackit: 1'b0, stop: 1'b0, nxt: st}; // [RQ16]
      if (st == ICD_MTX && run && sta)
      begin
         if (!dir)
            a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, sto,
               sto ? ICD_IDLE : ICD_MTX}; // [RQ14] [RQ12]
         else if (!ack && sto)
            a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, ICD_IDLE}; // [RQ1]
         else if (ack && !sto)
            a = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, ICD_MRX}; // [RQ2]
         else if (!ack && !sto)
            a = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, ICD_MRX};
      end
      else if (st == ICD_MRX)
      begin
         if (!sta && sto && !run)
            a = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, ICD_IDLE}; // [RQ4]
         else if (!sta && run && !(ack && sto))
            a = '{1'b1, 1'b0, 1'b0, 1'b1, ack, sto,
               sto ? ICD_IDLE : ICD_MRX}; // [RQ3] [RQ5] [RQ6] [RQ12]
         else if (sta && run && !dir)
            a = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, sto,
               sto ? ICD_IDLE : ICD_MTX}; // [RQ10] [RQ11] [RQ12]
         else if (sta && run && !(ack && sto))
            a = '{1'b1, 1'b1, 1'b0, 1'b1, ack, sto,
               sto ? ICD_IDLE : ICD_MRX}; // [RQ7] [RQ8] [RQ9]
      end
      return a;
   endfunction

   // pin synchronisers
   logic [1:0] scl_sync_r, sda_sync_r;
   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         scl_sync_r <= 2'b11;
         sda_sync_r <= 2'b11;
      end
      else
      begin
         scl_sync_r <= {scl_sync_r[0], scl_in};
         sda_sync_r <= {sda_sync_r[0], sda_in};
      end
   end
   logic sda_s;
   logic scl_s;
   assign sda_s = sda_sync_r[1];
   assign scl_s = scl_sync_r[1];

   // registers
   logic [7:0] addr_r, addr_nxt, data_r, data_nxt;
   icd_mstate_t mst_r, mst_nxt;
   logic err_r, err_nxt;
   logic awp_r, awp_nxt, wp_r, wp_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [7:0] awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

   // bus engine state
   icd_bstate_t bst_r, bst_nxt;
   icd_act_t act_r, act_nxt;
   logic [15:0] tick_r, tick_nxt;
   logic [1:0] ph_r, ph_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [8:0] sh_r, sh_nxt;
   logic scl_r, scl_nxt, sda_r, sda_nxt, nacked_r, nacked_nxt;
   logic adr_r, adr_nxt;
   logic qtick, busy;

   // received byte fifo
   logic rx_push, rx_room;
   icd_fifo #(.WIDTH(8), .DEPTH(ICD_FIFO_DEPTH)) rx_fifo (
      .clk_sys_in(clk_sys_in),
      .reset_in(reset_in),
      .in_valid_in(rx_push),
      .in_ready_out(rx_room),
      .in_data_in(sh_r[7:0]),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in),
      .out_data_out(rx_data_out)
   );

   assign busy = bst_r != ICD_B_IDLE;
   // quarter-period enable; stalls while a target holds scl low
   assign qtick = tick_r == 16'(QUARTER_CYC - 1);

   // axi slave and command issue
   logic do_wr;
   icd_act_t cmd;
   always_comb
   begin
      awp_nxt = awp_r;
      wp_nxt = wp_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      bv_nxt = bv_r;
      br_nxt = br_r;
      rv_nxt = rv_r;
      rd_nxt = rd_r;
      rr_nxt = rr_r;
      addr_nxt = addr_r;
      err_nxt = err_r;
      cmd = '0;
      if (s_axi_awvalid && !awp_r)
      begin
         awp_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wp_r)
      begin
         wp_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
      end
      do_wr = awp_r && wp_r && !bv_r;
      if (do_wr)
      begin
         awp_nxt = 1'b0;
         wp_nxt = 1'b0;
         bv_nxt = 1'b1;
         br_nxt = ICD_RESP_OKAY;
         unique case (awa_r & 8'hfc)
            ICD_SLAVE_ADDRESS_OFS: addr_nxt = wd_r[7:0];
            ICD_CONTROL_STATUS_OFS:
            begin
               // commands written while busy are dropped
               if (!busy)
                  cmd = decode(mst_r, addr_r[ICD_DIR_BIT], wd_r[3:0]);
            end
            ICD_DATA_OFS: ;
            default: br_nxt = ICD_RESP_SLVERR;
         endcase
      end
      if (bv_r && s_axi_bready)
         bv_nxt = 1'b0;
      if (s_axi_arvalid && !rv_r)
      begin
         rv_nxt = 1'b1;
         rr_nxt = ICD_RESP_OKAY;
         unique case (s_axi_araddr & 8'hfc)
            ICD_SLAVE_ADDRESS_OFS: rd_nxt = {24'h0, addr_r};
            ICD_CONTROL_STATUS_OFS: rd_nxt = {30'h0, err_r, busy};
            ICD_DATA_OFS: rd_nxt = {24'h0, data_r};
            ICD_STATE_OFS: rd_nxt = {30'h0, mst_r};
            default:
            begin
               rd_nxt = 32'h0;
               rr_nxt = ICD_RESP_SLVERR;
            end
         endcase
      end
      else if (rv_r && s_axi_rready)
         rv_nxt = 1'b0;
      if (cmd.go)
         err_nxt = 1'b0;
      else if (bst_r == ICD_B_ACK && qtick && ph_r == 2'd2 &&
         (act_r.xmit || adr_r) && sda_s)
         err_nxt = 1'b1;
   end

   assign s_axi_awready = !awp_r;
   assign s_axi_wready = !wp_r;
   assign s_axi_bvalid = bv_r;
   assign s_axi_bresp = br_r;
   assign s_axi_arready = !rv_r;
   assign s_axi_rvalid = rv_r;
   assign s_axi_rdata = rd_r;
   assign s_axi_rresp = rr_r;

   // bus engine: each bit spans four quarter ticks
   always_comb
   begin
      bst_nxt = bst_r;
      act_nxt = act_r;
      ph_nxt = ph_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      scl_nxt = scl_r;
      sda_nxt = sda_r;
      nacked_nxt = nacked_r;
      adr_nxt = adr_r;
      mst_nxt = mst_r;
      data_nxt = data_r;
      rx_push = 1'b0;
      // a target may stretch scl: the count waits until the line is high
      if (qtick || !busy)
         tick_nxt = 16'h0;
      else if (scl_r && !scl_s)
         tick_nxt = tick_r;
      else
         tick_nxt = tick_r + 16'h1;
      if (do_wr && (awa_r & 8'hfc) == ICD_DATA_OFS && !busy)
         data_nxt = wd_r[7:0]; // [RQ15]
      if (cmd.go)
      begin
         act_nxt = cmd;
         mst_nxt = cmd.nxt;
         ph_nxt = 2'd0;
         bit_nxt = 4'd0;
         nacked_nxt = 1'b0;
         // a restart first sends the address byte with its direction bit
         sh_nxt = cmd.restart ? {addr_r, 1'b1} : {data_r, 1'b1}; // [RQ15]
         adr_nxt = cmd.restart;
         bst_nxt = cmd.restart ? ICD_B_START :
            (cmd.xmit || cmd.recv) ? ICD_B_BIT : ICD_B_STOP;
      end
      else if (busy && qtick)
      begin
         ph_nxt = ph_r + 2'd1;
         unique case (bst_r)
            ICD_B_START:
            begin
               // release sda, then raise scl, then pull sda low with scl high
               unique case (ph_r)
                  2'd0: sda_nxt = 1'b1;
                  2'd1: scl_nxt = 1'b1;
                  2'd2: sda_nxt = 1'b0;
                  2'd3:
                  begin
                     scl_nxt = 1'b0;
                     bst_nxt = ICD_B_BIT;
                  end
               endcase
            end
            ICD_B_BIT:
            begin
               unique case (ph_r)
                  2'd0: sda_nxt = (act_r.xmit || adr_r) ? sh_r[8] : 1'b1;
                  2'd1: scl_nxt = 1'b1;
                  2'd2: sh_nxt = {sh_r[7:0], sda_s};
                  2'd3:
                  begin
                     scl_nxt = 1'b0;
                     bit_nxt = bit_r + 4'd1;
                     if (bit_r == 4'd7)
                        bst_nxt = ICD_B_ACK;
                  end
               endcase
            end
            ICD_B_ACK:
            begin
               unique case (ph_r)
                  // receiver acks or nacks per command
                  2'd0: sda_nxt = (act_r.recv && !adr_r) ?
                     !act_r.ackit : 1'b1; // [RQ3]
                  2'd1: scl_nxt = 1'b1;
                  2'd2: nacked_nxt = (act_r.xmit || adr_r) && sda_s;
                  2'd3:
                  begin
                     if (adr_r)
                     begin
                        // a refused address skips the data byte
                        scl_nxt = 1'b0;
                        adr_nxt = 1'b0;
                        bit_nxt = 4'd0;
                        sh_nxt = {data_r, 1'b1}; // [RQ15]
                        if (!nacked_r)
                           bst_nxt = ICD_B_BIT;
                        else if (act_r.stop)
                           bst_nxt = ICD_B_STOP;
                        else
                           bst_nxt = ICD_B_IDLE;
                     end
                     else if (act_r.recv && !rx_room)
                        ph_nxt = ph_r; // hold scl high until room
                     else
                     begin
                        scl_nxt = 1'b0;
                        if (act_r.recv)
                        begin
                           data_nxt = sh_r[7:0]; // [RQ15]
                           rx_push = 1'b1;
                        end
                        bst_nxt = act_r.stop ? ICD_B_STOP : ICD_B_IDLE;
                     end
                  end
               endcase
            end
            ICD_B_STOP:
            begin
               unique case (ph_r)
                  2'd0: sda_nxt = 1'b0;
                  2'd1: scl_nxt = 1'b1;
                  2'd2: sda_nxt = 1'b1; // [RQ4] [RQ13]
                  2'd3: bst_nxt = ICD_B_IDLE;
               endcase
            end
            default: bst_nxt = ICD_B_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         awp_r <= 1'b0;
         wp_r <= 1'b0;
         awa_r <= 8'h00;
         wd_r <= 32'h0;
         bv_r <= 1'b0;
         br_r <= 2'h0;
         rv_r <= 1'b0;
         rd_r <= 32'h0;
         rr_r <= 2'h0;
         addr_r <= ICD_ADDR_RST;
         data_r <= ICD_DATA_RST;
         err_r <= 1'b0;
         mst_r <= ICD_MTX;
         bst_r <= ICD_B_IDLE;
         act_r <= '0;
         tick_r <= 16'h0;
         ph_r <= 2'd0;
         bit_r <= 4'd0;
         sh_r <= 9'h1ff;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         nacked_r <= 1'b0;
         adr_r <= 1'b0;
      end
      else
      begin
         awp_r <= awp_nxt;
         wp_r <= wp_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         bv_r <= bv_nxt;
         br_r <= br_nxt;
         rv_r <= rv_nxt;
         rd_r <= rd_nxt;
         rr_r <= rr_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         err_r <= err_nxt;
         mst_r <= mst_nxt;
         bst_r <= bst_nxt;
         act_r <= act_nxt;
         tick_r <= tick_nxt;
         ph_r <= ph_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         scl_r <= scl_nxt;
         sda_r <= sda_nxt;
         nacked_r <= nacked_nxt;
         adr_r <= adr_nxt;
      end
   end

   // open drain: enable only while pulling low
   assign scl_out = 1'b0;
   assign scl_oe_out = !scl_r;
   assign sda_out = 1'b0;
   assign sda_oe_out = !sda_r;
endmodule

/* bench/icd_slave_model.sv */
// behavioural i2c target on the open-drain pair
`timescale 1ns/10ps
module icd_slave_model #(
   parameter logic [6:0] ADDR = 7'h2a,
   parameter logic [7:0] TX0 = 8'ha5
)(
   // clock and bus levels
   input wire logic clk_sys_in,
   input wire logic scl_in,
   input wire logic sda_in,
   // drive and observation
   output logic sda_oe_out,
   output logic [7:0] last_byte_out,
   output logic ack_seen_out,
   output int n_start_out,
   output int n_stop_out
);
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic rd = 1'b0;
   logic [7:0] sh = 8'h00;
   logic [7:0] tx = TX0;
   int cnt = 0;
   int ph = 3;
   initial
   begin
      sda_oe_out = 1'b0;
      last_byte_out = 8'h00;
      ack_seen_out = 1'b1;
      n_start_out = 0;
      n_stop_out = 0;
   end
   // next byte only after an ack; every byte has msb 1 so a restart is free
   always @(posedge clk_sys_in)
   begin
      if (scl_in && scl_q && sda_q && !sda_in)
      begin
         n_start_out++;
         cnt = -1;
         ph = 0;
         sda_oe_out <= 1'b0;
      end
      else if (scl_in && scl_q && !sda_q && sda_in)
      begin
         n_stop_out++;
         ph = 3;
         sda_oe_out <= 1'b0;
      end
      else if (scl_in && !scl_q && cnt >= 0 && cnt < 8)
         sh = {sh[6:0], sda_in};
      else if (scl_in && !scl_q && cnt == 8 && ph == 2)
         ack_seen_out = sda_in;
      else if (!scl_in && scl_q && ph < 3)
      begin
         cnt++;
         if (cnt == 8)
         begin
            last_byte_out = sh;
            if (ph == 0)
               rd = sh[0];
            if (ph == 0 && sh[7:1] != ADDR)
               ph = 3;
            sda_oe_out <= (ph < 2);
         end
         else if (cnt == 9)
         begin
            cnt = 0;
            if (ph == 2 && ack_seen_out)
               ph = 3;
            else if (ph == 2)
               tx++;
            if (ph == 0)
               ph = rd ? 2 : 1;
            sda_oe_out <= (ph == 2) && !tx[7];
         end
         else
            sda_oe_out <= (ph == 2) && !tx[7-cnt];
      end
      scl_q = scl_in;
      sda_q = sda_in;
   end
endmodule

/* bench/icd_top_properties.sv */
// port assertions for the command decoder top
`timescale 1ns/10ps
module icd_top_properties
   import icd_pkg::*;
#(
   parameter int QUARTER_CYC = ICD_QUARTER_CYC
)(
   // watched ports
   input wire logic clk_sys_in,
   input wire logic reset_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic scl_oe_out,
   input wire logic sda_oe_out,
   input wire logic rx_valid_out,
   input wire logic rx_ready_in,
   input wire logic [7:0] rx_data_out
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (reset_in);
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   a_write_latency: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr & 8'hfc) > ICD_STATE_OFS |=>
      s_axi_rresp == ICD_RESP_SLVERR)
      else $error("unmapped read not refused");
   a_err_data_zero: assert property (s_axi_rvalid &&
      s_axi_rresp == ICD_RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("refused read carries data");
   a_rx_hold: assert property (
      rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
      else $error("received byte lost");
   a_reset_quiet: assert property ($fell(reset_in) |->
      !scl_oe_out && !sda_oe_out && !rx_valid_out)
      else $error("bus driven after reset");
   a_nop_quiet: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_awaddr == ICD_CONTROL_STATUS_OFS && s_axi_wdata[3:0] == 4'h0 |=>
      ($stable(scl_oe_out) && $stable(sda_oe_out))[*8])
      else $error("empty command moved the bus");
endmodule
bind icd_top icd_top_properties #(.QUARTER_CYC(QUARTER_CYC)) u_props (.*);

/* bench/tb_top.sv */
// self-checking bench for the i2c command decoder top
`timescale 1ns/10ps
module tb_top
   import icd_pkg::*;
;
   localparam int QC = 5;
   localparam logic [6:0] SLV = 7'h2a;
   localparam int NS = 23;
   // step: cmd[3:0] dir[4] state[6:5] start[7] stop[8] kind[10:9] reset[11]
   localparam logic [11:0] STEPS [NS] = '{
      12'h2ab, 12'h2a3, // send and stay
      12'h03f, 12'h020, 12'h4db, // refused, empty, to receive
      12'h449, 12'h651, 12'h05d, // ack, nack, refused
      12'h6d3, 12'h4db, 12'h2ab, // restarts
      12'h4db, 12'h2a3, 12'h997, // back to send, stop
      12'h4db, 12'hf15, // receive then stop
      12'h4db, 12'h651, 12'h90c, // stop only after a nack
      12'h4db, 12'hf97, 12'h4db, 12'hb8f // restart and stop
   };
   logic clk_sys_in = 1'b0;
   logic reset_in = 1'b1;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic rx_ready_in = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, scl_out, scl_oe_out, sda_out, sda_oe_out;
   logic rx_valid_out, sl_oe, sl_ack, scl_in, sda_in;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] s_axi_rdata, rdv;
   logic [7:0] rx_data_out, sl_byte;
   logic [7:0] exp_rx = 8'ha5;
   logic [11:0] s;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_st, n_sp, ns0, np0;
   // pull-ups: a released line reads high
   assign scl_in = !scl_oe_out;
   assign sda_in = !(sda_oe_out || sl_oe);
   icd_top #(.QUARTER_CYC(QC)) uut (.*);
   icd_slave_model #(.ADDR(SLV), .TX0(8'ha5)) slave (
      .clk_sys_in(clk_sys_in), .scl_in(scl_in), .sda_in(sda_in),
      .sda_oe_out(sl_oe), .last_byte_out(sl_byte), .ack_seen_out(sl_ack),
      .n_start_out(n_st), .n_stop_out(n_sp));
   initial
   begin
      forever #4 clk_sys_in = ~clk_sys_in;
   end
   task automatic close_out;
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_sys_in)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_errors++;
         $display("BAD %0t timeout", $time);
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset;
      @(posedge clk_sys_in);
      reset_in <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
      reset_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk_sys_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w))
      begin
         @(posedge clk_sys_in);
         aw = aw || (s_axi_awready === 1'b1);
         w = w || (s_axi_wready === 1'b1);
         if (aw)
            s_axi_awvalid <= 1'b0;
         if (w)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1)
         @(posedge clk_sys_in);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys_in);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys_in); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1)
         @(posedge clk_sys_in);
      rdv = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // busy rises in the same cycle as the write answer; wait four cycles, then poll
   task automatic cmd(input logic [3:0] c);
      wr(ICD_CONTROL_STATUS_OFS, {28'h0, c});
      chk(32'(rsp), 32'(ICD_RESP_OKAY));
      repeat (4) @(posedge clk_sys_in);
      do rd(ICD_CONTROL_STATUS_OFS); while (rdv[ICD_BUSY_BIT] !== 1'b0);
   endtask
   task automatic pop(input logic [7:0] e);
      chk(32'(rx_valid_out), 32'h1);
      chk(32'(rx_data_out), 32'(e));
      @(posedge clk_sys_in);
      rx_ready_in <= 1'b1;
      @(posedge clk_sys_in);
      rx_ready_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   initial
   begin
      do_reset();
      rd(ICD_SLAVE_ADDRESS_OFS);
      chk(rdv, 32'(ICD_ADDR_RST));
      rd(ICD_DATA_OFS);
      chk(rdv, 32'(ICD_DATA_RST));
      rd(ICD_STATE_OFS);
      chk(rdv, 32'h1);
      rd(8'h40);
      chk(32'(rsp), 32'(ICD_RESP_SLVERR));
      // fill the byte buffer with its drain side stalled, then empty it
      wr(ICD_SLAVE_ADDRESS_OFS, {24'h0, SLV, 1'b1});
      for (int k = 0; k < ICD_FIFO_DEPTH; k++)
         cmd(k == 0 ? 4'hb : 4'h9);
      for (int k = 0; k < ICD_FIFO_DEPTH; k++)
      begin
         pop(exp_rx);
         exp_rx++;
      end
      chk(32'(rx_valid_out), 32'h0);
      do_reset();
      for (int i = 0; i < NS; i++)
      begin
         s = STEPS[i];
         ns0 = n_st;
         np0 = n_sp;
         wr(ICD_SLAVE_ADDRESS_OFS, {24'h0, SLV, s[4]});
         wr(ICD_DATA_OFS, 32'(8'h30 + i));
         cmd(s[3:0]);
         rd(ICD_STATE_OFS);
         chk(rdv, {30'h0, s[6:5]});
         chk(n_st - ns0, 32'(s[7]));
         chk(n_sp - np0, 32'(s[8]));
         if (s[10:9] == 2'h1)
            chk(32'(sl_byte), 32'(8'h30 + i));
         if (s[10])
         begin
            pop(exp_rx);
            chk(32'(sl_ack), 32'(s[9]));
            rd(ICD_DATA_OFS);
            chk(rdv, 32'(exp_rx));
            if (!s[9])
               exp_rx++;
         end
         if (s[11])
            do_reset();
      end
      close_out();
   end
endmodule
